// >>> rtl/branch_and_addr_subtract_exec.v
// Purpose: executes extended address subtract, branches and memory AND test
// Assumes: software loads instruction bytes over APB and pulses go
// Notes:   one instruction at a time; busy holds for its cycle cost
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.vh"
// Function
// RQ1 - extended subtract writes destination minus source, full width, into destination
// RQ2 - circular mode bit set on auxiliary destination wraps result in buffer
// RQ3 - accumulator branch loads PC with low 24 accumulator bits, 10 cycles
// RQ4 - accumulator branch is two bytes, fixed first byte, low bits pick accumulator
// RQ5 - short and long relative branches jump to label, 6 cycles
// RQ6 - relative branch costs 3 cycles when target is already buffered
// RQ7 - absolute branch loads 24-bit address, four bytes, 5 cycles
// RQ8 - no branch accepted as target of single-instruction repeat
// RQ9 - memory AND immediate sets test flag if nonzero, clears if zero, 1 cycle
// RQ10 - first byte picks test flag; AND result not written back
// RQ11 - conditional branch tests one condition field, jumps only when true
// RQ12 - condition sees flag updates one cycle late
// RQ13 - conditional branch costs 6 taken, 5 not taken
// RQ14 - conditional forms: 3 and 4 bytes carry 7-bit condition then offset
// RQ15 - conditions use overflow, carry, test flags, compat and wide mode
// RQ16 - compat mode compares accumulator with zero on full 40 bits
// RQ17 - testing an overflow flag clears it
module branch_and_addr_subtract_exec (
   input  wire        pclk,      // core clock
   input  wire        presetn,   // async reset, active low
   input  wire        psel,      // apb select
   input  wire        penable,   // apb access phase
   input  wire        pwrite,    // apb direction
   input  wire [7:0]  paddr,     // apb byte address
   input  wire [31:0] pwdata,    // apb write data
   output reg  [31:0] prdata,    // apb read data
   output reg         pready,    // apb ready
   output reg         pslverr,   // apb error, unmapped address
   output reg  [23:0] pc_out     // program counter
);
   localparam IDLE = 1'b0;
   localparam BUSY = 1'b1;

   reg        state;
   reg [3:0]  remain;
   reg [31:0] instr0;
   reg [7:0]  instr1;
   reg        ibuf_hit;
   reg        repeat_on;
   reg        reject;
   reg [23:0] pc;
   reg [15:0] memop;
   reg [1:0]  acc_idx;
   reg [3:0]  xar_idx;
   reg [3:0]  cycles;
   reg [31:0] circ_cfg;
   reg        tc1;
   reg        tc2;
   reg        carry;
   reg [3:0]  acov;
   reg        compat;
   reg        wide;
   reg [7:0]  circ_bits;
   reg [9:0]  flags_late;
   reg [39:0] acc [0:3];
   reg [22:0] xar [0:8];

   reg [23:0] next_pc;
   reg [3:0]  next_cost;
   reg        next_reject;
   reg        next_tc1;
   reg        next_tc2;
   reg [3:0]  next_acov;
   reg        xar_we;
   reg        exec_ok;
   reg        is_branch;
   reg        hit_addr;
   reg [31:0] rd;

   wire [7:0]  b0 = instr0[31:24];
   wire [7:0]  b1 = instr0[23:16];
   wire [7:0]  b2 = instr0[15:8];
   wire [7:0]  b3 = instr0[7:0];
   wire [3:0]  x_src = b1[7:4];
   wire [3:0]  x_dst = b2[7:4];
   wire [22:0] x_res;
   wire        take;
   wire [3:0]  ovf_clr;
   wire        wr_en = psel & penable & pready & pwrite;
   wire        go = wr_en & (paddr == `ADDR_CTRL) & pwdata[`CTRL_GO] & (state == IDLE);

   // relative target: offset counts from the next instruction
   function [23:0] rel_target;
      input [23:0] base;
      input [15:0] off;
      input [23:0] size;
      begin
         rel_target = base + size + {{8{off[15]}}, off};
      end
   endfunction

   // condition flags come from a one-cycle-late copy; the accumulator is read directly
   cond_check u_cond (
      .cond    (b1[6:0]),                                    // [RQ11] [RQ14]
      .acc     (acc[b1[1:0]]),
      .acov    (flags_late[7:4]),                            // [RQ12]
      .carry   (flags_late[2]),
      .tc1     (flags_late[0]),
      .tc2     (flags_late[1]),
      .compat  (flags_late[8]),
      .wide    (flags_late[9]),
      .take    (take),
      .ovf_clr (ovf_clr)
   );

   circ_subtract u_sub (
      .dst     (xar[x_dst]),
      .src     (xar[x_src]),
      .circ_en (circ_bits[x_dst[2:0]] & (x_dst != `XIDX_COEF)), // [RQ2]
      .start   (circ_cfg[15:0]),
      .size    (circ_cfg[31:16]),
      .result  (x_res)
   );

   // decode and execute the loaded instruction
   always @*
   begin
      next_pc     = pc;
      next_cost   = `CYC_ONE;
      next_reject = 1'b0;
      next_tc1    = tc1;
      next_tc2    = tc2;
      next_acov   = acov;
      xar_we      = 1'b0;
      exec_ok     = 1'b1;
      is_branch   = 1'b1;
      hit_addr    = 1'b0;
      if (b0[7:1] == `OP_XSUB && b1[3:0] == `OP_XSUB_B1LO)
      begin
         is_branch = 1'b0;
         xar_we    = (x_src <= `XAR_LAST) && (x_dst <= `XAR_LAST); // [RQ1]
         next_pc   = pc + `SZ3;
      end
      else if (b0 == `OP_B_ACC)
      begin
         next_pc   = acc[b1[1:0]][23:0];                     // [RQ3] [RQ4]
         next_cost = `CYC_B_ACC;                             // [RQ3]
      end
      else if (b0[7:1] == `OP_B_L7)
      begin
         next_pc   = rel_target(pc, {{9{b1[6]}}, b1[6:0]}, `SZ2); // [RQ5]
         next_cost = ibuf_hit ? `CYC_B_HIT : `CYC_B_REL;     // [RQ6]
      end
      else if (b0[7:1] == `OP_B_L16)
      begin
         next_pc   = rel_target(pc, {b1, b2}, `SZ3);         // [RQ5]
         next_cost = ibuf_hit ? `CYC_B_HIT : `CYC_B_REL;     // [RQ6]
      end
      else if (b0 == `OP_B_P24)
      begin
         next_pc   = {b1, b2, b3};                           // [RQ7]
         next_cost = `CYC_B_P24;                             // [RQ7]
      end
      else if (b0[7:4] == `OP_TEST_HI && (b0[3:0] == `OP_TEST_TC1 || b0[3:0] == `OP_TEST_TC2))
      begin
         is_branch = 1'b0;
         // only the picked test flag and pc change; memory keeps its value
         hit_addr  = ((memop & {b2, b3}) != 16'h0000);        // [RQ9]
         if (b0[3:0] == `OP_TEST_TC1)
            next_tc1 = hit_addr;                             // [RQ10]
         else
            next_tc2 = hit_addr;                             // [RQ10]
         next_pc = pc + `SZ4;
      end
      else if (b0[7:1] == `OP_BCC_L8)
      begin
         next_pc   = take ? rel_target(pc, {{8{b2[7]}}, b2}, `SZ3) : pc + `SZ3; // [RQ11]
         next_cost = take ? `CYC_BCC_T : `CYC_BCC_F;         // [RQ13]
         next_acov = acov & ~ovf_clr;                        // [RQ17]
      end
      else if (b0 == `OP_BCC_L16)
      begin
         next_pc   = take ? rel_target(pc, {b2, b3}, `SZ4) : pc + `SZ4; // [RQ11]
         next_cost = take ? `CYC_BCC_T : `CYC_BCC_F;         // [RQ13]
         next_acov = acov & ~ovf_clr;                        // [RQ17]
      end
      else
      begin
         is_branch = 1'b0;
         exec_ok   = 1'b0;
      end
      if (is_branch && repeat_on)
         exec_ok = 1'b0;                                     // [RQ8]
      if (!exec_ok)
      begin
         next_reject = 1'b1;
         next_pc     = pc;
         next_cost   = `CYC_ONE;
         next_tc1    = tc1;
         next_tc2    = tc2;
         next_acov   = acov;
         xar_we      = 1'b0;
      end
   end

   // read mux
   always @*
   begin
      rd = 32'h0000_0000;
      case (paddr)
         `ADDR_INSTR0:  rd = instr0;
         `ADDR_INSTR1:  rd = {24'h00_0000, instr1};
         `ADDR_CTRL:    rd = {22'h00_0000, reject, state, 5'h00, repeat_on, ibuf_hit, 1'b0};
         `ADDR_FLAGS:   rd = {8'h00, circ_bits, 6'h00, wide, compat, acov, 1'b0, carry, tc2, tc1};
         `ADDR_PC:      rd = {8'h00, pc};
         `ADDR_MEMOP:   rd = {16'h0000, memop};
         `ADDR_ACC_IDX: rd = {30'h0000_0000, acc_idx};
         `ADDR_ACC_LO:  rd = acc[acc_idx][31:0];
         `ADDR_ACC_HI:  rd = {24'h00_0000, acc[acc_idx][39:32]};
         `ADDR_XAR_IDX: rd = {28'h000_0000, xar_idx};
         `ADDR_XAR:     rd = {9'h000, xar[xar_idx]};
         `ADDR_CYCLES:  rd = {28'h000_0000, cycles};
         `ADDR_CIRC:    rd = circ_cfg;
         default:       rd = 32'h0000_0000;
      endcase
   end

   // apb answer: ready in the cycle after setup, no wait states
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         if (psel & ~penable)
         begin
            prdata  <= pwrite ? 32'h0000_0000 : rd;
            pslverr <= (paddr > `ADDR_CIRC) | (paddr[1:0] != 2'b00);
         end
      end
   end

   // execution state, flags and register files
   always @(posedge pclk or negedge presetn)
   begin : seq
      integer i;
      if (!presetn)
      begin
         state      <= IDLE;
         remain     <= 4'h0;
         instr0     <= 32'h0000_0000;
         instr1     <= 8'h00;
         ibuf_hit   <= 1'b0;
         repeat_on  <= 1'b0;
         reject     <= 1'b0;
         pc         <= 24'h00_0000;
         pc_out     <= 24'h00_0000;
         memop      <= 16'h0000;
         acc_idx    <= 2'h0;
         xar_idx    <= 4'h0;
         cycles     <= 4'h0;
         circ_cfg   <= 32'h0000_0000;
         tc1        <= 1'b0;
         tc2        <= 1'b0;
         carry      <= 1'b0;
         acov       <= 4'h0;
         compat     <= 1'b0;
         wide       <= 1'b0;
         circ_bits  <= 8'h00;
         flags_late <= 10'h000;
         for (i = 0; i < 4; i = i + 1)
            acc[i] <= 40'h00_0000_0000;
         for (i = 0; i < 9; i = i + 1)
            xar[i] <= 23'h00_0000;
      end
      else
      begin
         // flags reach the condition logic one cycle late
         flags_late <= {wide, compat, acov, 1'b0, carry, tc2, tc1}; // [RQ12]
         pc_out     <= pc;
         if (state == BUSY)
         begin
            remain <= remain - 4'h1;
            if (remain == 4'h1)
               state <= IDLE;
         end
         if (wr_en && state == IDLE)
         begin
            case (paddr)
               `ADDR_INSTR0:  instr0 <= pwdata;
               `ADDR_INSTR1:  instr1 <= pwdata[7:0];
               `ADDR_CTRL:
               begin
                  ibuf_hit  <= pwdata[`CTRL_IBUF_HIT];
                  repeat_on <= pwdata[`CTRL_REPEAT];
               end
               `ADDR_FLAGS:
               begin
                  tc1       <= pwdata[`FL_TC1];
                  tc2       <= pwdata[`FL_TC2];
                  carry     <= pwdata[`FL_CARRY];
                  acov      <= pwdata[`FL_ACOV_LSB+3:`FL_ACOV_LSB];
                  compat    <= pwdata[`FL_COMPAT];
                  wide      <= pwdata[`FL_WIDE];
                  circ_bits <= pwdata[`FL_CIRC_LSB+7:`FL_CIRC_LSB];
               end
               `ADDR_PC:      pc <= pwdata[23:0];
               `ADDR_MEMOP:   memop <= pwdata[15:0];
               `ADDR_ACC_IDX: acc_idx <= pwdata[1:0];
               `ADDR_ACC_LO:  acc[acc_idx][31:0] <= pwdata;
               `ADDR_ACC_HI:  acc[acc_idx][39:32] <= pwdata[7:0];
               `ADDR_XAR_IDX: xar_idx <= (pwdata[3:0] > `XAR_LAST) ? `XAR_LAST : pwdata[3:0];
               `ADDR_XAR:     xar[xar_idx] <= pwdata[22:0];
               `ADDR_CIRC:    circ_cfg <= pwdata;
               default:       cycles <= cycles;
            endcase
         end
         // go commits architectural results at once, busy covers the cost
         if (go)
         begin
            pc     <= next_pc;
            reject <= next_reject;
            tc1    <= next_tc1;
            tc2    <= next_tc2;
            acov   <= next_acov;
            cycles <= next_cost;
            remain <= next_cost;
            state  <= BUSY;
            if (xar_we)
               xar[x_dst] <= x_res;                          // [RQ1] [RQ2]
         end
      end
   end
endmodule // branch_and_addr_subtract_exec
`default_nettype wire

// >>> rtl/exec_consts.vh
// Purpose: constants for the branch and address-subtract execution block
// Assumes: 32-bit APB data, byte addresses, 125 MHz pclk
// Notes:   header only, no logic
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH
// register byte offsets
`define ADDR_INSTR0   8'h00
`define ADDR_INSTR1   8'h04
`define ADDR_CTRL     8'h08
`define ADDR_FLAGS    8'h0c
`define ADDR_PC       8'h10
`define ADDR_MEMOP    8'h14
`define ADDR_ACC_IDX  8'h18
`define ADDR_ACC_LO   8'h1c
`define ADDR_ACC_HI   8'h20
`define ADDR_XAR_IDX  8'h24
`define ADDR_XAR      8'h28
`define ADDR_CYCLES   8'h2c
`define ADDR_CIRC     8'h30
// ctrl fields
`define CTRL_GO       0
`define CTRL_IBUF_HIT 1
`define CTRL_REPEAT   2
`define CTRL_BUSY     8
`define CTRL_REJECT   9
// flags fields
`define FL_TC1        0
`define FL_TC2        1
`define FL_CARRY      2
`define FL_ACOV_LSB   4
`define FL_COMPAT     8
`define FL_WIDE       9
`define FL_CIRC_LSB   16
// first opcode bytes (top seven bits where the low bit is parallel enable)
`define OP_XSUB       7'h0a
`define OP_XSUB_B1LO  4'h1
`define OP_B_ACC      8'h91
`define OP_B_L7       7'h25
`define OP_B_L16      7'h03
`define OP_B_P24      8'h6a
`define OP_TEST_HI    4'hf
`define OP_TEST_TC1   4'h2
`define OP_TEST_TC2   4'h3
`define OP_BCC_L8     7'h02
`define OP_BCC_L16    8'h6d
// instruction sizes in bytes
`define SZ2           24'h00_0002
`define SZ3           24'h00_0003
`define SZ4           24'h00_0004
// cycle costs
`define CYC_ONE       4'h1
`define CYC_B_ACC     4'ha
`define CYC_B_REL     4'h6
`define CYC_B_HIT     4'h3
`define CYC_B_P24     4'h5
`define CYC_BCC_T     4'h6
`define CYC_BCC_F     4'h5
// index of coefficient pointer in extended address file
`define XIDX_COEF     4'h8
`define XAR_LAST      4'h8
`endif

// >>> rtl/cond_check.v
// Purpose: evaluate one branch condition against delayed flags
// Assumes: flag inputs are already one cycle late
// Notes:   combinational
`timescale 1ns/1ps
`default_nettype none
module cond_check (
   input  wire [6:0]  cond,      // condition field
   input  wire [39:0] acc,       // accumulator picked by cond[1:0]
   input  wire [3:0]  acov,      // accumulator overflow flags
   input  wire        carry,     // carry flag
   input  wire        tc1,       // first test flag
   input  wire        tc2,       // second test flag
   input  wire        compat,    // legacy compatibility mode
   input  wire        wide,      // 40-bit overflow mode
   output reg         take,      // condition true
   output reg  [3:0]  ovf_clr    // overflow flag consumed
);
   reg w40;
   reg neg;
   reg zero;
   // legacy mode forces full-width zero compare
   always @*
   begin
      w40     = wide | compat;                               // [RQ16] [RQ15]
      neg     = w40 ? acc[39] : acc[31];
      zero    = w40 ? (acc == 40'h00_0000_0000) : (acc[31:0] == 32'h0000_0000);
      take    = 1'b0;
      ovf_clr = 4'h0;
      case (cond[6:5])
         2'b00:
         begin
            case (cond[4:2])
               3'h0:    take = zero;
               3'h1:    take = ~zero;
               3'h2:    take = neg;
               3'h3:    take = neg | zero;
               3'h4:    take = ~neg & ~zero;
               default: take = ~neg;
            endcase
         end
         2'b01:
         begin
            take = acov[cond[1:0]] ^ cond[2];
            ovf_clr[cond[1:0]] = 1'b1;                        // [RQ17]
         end
         2'b10:   take = carry ^ cond[0];
         default: take = (cond[0] ? tc2 : tc1) ^ cond[1];
      endcase
   end
endmodule // cond_check
`default_nettype wire

// >>> rtl/circ_subtract.v
// Purpose: extended address subtract with optional circular wrap
// Assumes: circular buffer lives in the low 16 bits
// Notes:   combinational
`timescale 1ns/1ps
`default_nettype none
module circ_subtract (
   input  wire [22:0] dst,       // destination value
   input  wire [22:0] src,       // source value
   input  wire        circ_en,   // circular mode for this register
   input  wire [15:0] start,     // buffer start
   input  wire [15:0] size,      // buffer size
   output reg  [22:0] result     // value written back
);
   reg [16:0] low;
   reg [16:0] top;
   always @*
   begin
      low = {1'b0, dst[15:0]} - {1'b0, src[15:0]};
      top = {1'b0, start} + {1'b0, size};
      result = dst - src;                                    // [RQ1]
      // wrap once; a step larger than the buffer is not folded fully
      if (circ_en)
      begin
         if (low[16] || (low < {1'b0, start}))
            low = low + {1'b0, size};                         // [RQ2]
         else if (low >= top)
            low = low - {1'b0, size};                         // [RQ2]
         result = {dst[22:16], low[15:0]};
      end
   end
endmodule // circ_subtract
`default_nettype wire

// >>> verification/branch_and_addr_subtract_exec_chk.sv
// Purpose: port checker for the branch and address subtract block
// Assumes: every go is issued while the block is idle
// Notes:   shadows instruction and control writes seen on the bus
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.vh"
module exec_chk (
   input wire logic        pclk,    // clock
   input wire logic        presetn, // reset, low
   input wire logic        psel,    // select
   input wire logic        penable, // access
   input wire logic        pwrite,  // write
   input wire logic [7:0]  paddr,   // address
   input wire logic [31:0] pwdata,  // wdata
   input wire logic [31:0] prdata,  // rdata
   input wire logic        pready,  // ready
   input wire logic        pslverr, // error
   input wire logic [23:0] pc_out   // pc copy
);
   logic [31:0] i0;
   logic [7:0]  op;
   logic        ib, rp, hit, rep;
   // completed transfers and decoded opcode classes
   wire wr = psel & penable & pready & pwrite;
   wire rd = psel & penable & pready & ~pwrite;
   wire go = wr && paddr == `ADDR_CTRL && pwdata[0];
   wire cyc = rd && paddr == `ADDR_CYCLES && !rep;
   wire rel = op[7:1] == 7'h25 || op[7:1] == 7'h03;
   wire isbr = rel || op == 8'h91 || op == 8'h6a || op[7:1] == 7'h02 || op == 8'h6d;
   // ctrl bits of a go write only apply to the next go
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         i0 <= 32'h0000_0000;
         op <= 8'h00;
         {ib, rp, hit, rep} <= 4'h0;
      end
      else
      begin
         if (wr && paddr == `ADDR_INSTR0)
            i0 <= pwdata;
         if (wr && paddr == `ADDR_CTRL)
            {rp, ib} <= pwdata[2:1];
         if (go)
         begin
            op <= i0[31:24];
            {hit, rep} <= {ib, rp};
         end
      end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_acc_branch_cost: assert property (cyc && op == 8'h91 |-> prdata == 32'h0000_000a) else $error("acc cost");
   a_abs_branch_cost: assert property (cyc && op == 8'h6a |-> prdata == 32'h0000_0005) else $error("abs cost");
   a_rel_miss_cost: assert property (cyc && rel && !hit |-> prdata == 32'h0000_0006) else $error("rel cost");
   a_rel_hit_cost: assert property (cyc && rel && hit |-> prdata == 32'h0000_0003) else $error("hit cost");
   a_and_test_cost: assert property (cyc && op[7:1] == 7'h79 |-> prdata == 32'h0000_0001) else $error("test cost");
   a_cond_cost: assert property (cyc && (op[7:1] == 7'h02 || op == 8'h6d)
      |-> prdata == 32'h0000_0006 || prdata == 32'h0000_0005) else $error("cond cost");
   a_repeat_cost: assert property (rd && paddr == `ADDR_CYCLES && rep && isbr
      |-> prdata == 32'h0000_0001) else $error("repeat cost");
   a_repeat_pc_hold: assert property (go && rp && i0[31:24] == 8'h6a |=> $stable(pc_out) [*3])
      else $error("pc moved");
   a_abs_pc_load: assert property (go && !rp && i0[31:24] == 8'h6a |-> ##[1:3] pc_out == i0[23:0])
      else $error("abs pc");
   // main scenarios reached
   c_repeat: cover property (go && rp);
   c_hit: cover property (cyc && hit);
   c_err: cover property (rd && pslverr);
endmodule // exec_chk
bind branch_and_addr_subtract_exec exec_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_out(pc_out));
`default_nettype wire

// >>> verification/branch_and_addr_subtract_exec_bench.sv
// Purpose: self-checking bench for the branch and address subtract block
// Assumes: instructions loaded over apb, go written once idle
// Notes:   expectations computed here from opcode fields
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.vh"
module branch_and_addr_subtract_exec_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [23:0] pc_out;
   logic [31:0] rv;
   logic        se;
   int          err_total = 0;
   int          total_checks = 0;
   int          ticks = 0;
   // 125 MHz core clock
   always #4 pclk = ~pclk;
   branch_and_addr_subtract_exec DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pc_out(pc_out));
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // hang guard, generous against about a thousand cycles of traffic
   always @(posedge pclk)
   begin
      ticks++;
      if (ticks > 20000)
      begin
         err_total++;
         results;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rv = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // mode bits go in first, since a go write uses the old ones
   task automatic run(input logic [31:0] ins, input logic [31:0] c);
      xfer(1'b1, `ADDR_INSTR0, ins);
      xfer(1'b1, `ADDR_CTRL, c);
      xfer(1'b1, `ADDR_CTRL, c | 32'h0000_0001);
      do
         xfer(1'b0, `ADDR_CTRL, 32'h0000_0000);
      while (rv[8] === 1'b1);
   endtask
   task automatic pc_cyc(input logic [23:0] p, input logic [31:0] c);
      xfer(1'b0, `ADDR_PC, 32'h0000_0000);
      chk(rv, {8'h00, p});
      xfer(1'b0, `ADDR_CYCLES, 32'h0000_0000);
      chk(rv, c);
   endtask
   task automatic setpc(input logic [23:0] p);
      run({8'h6a, p}, 32'h0000_0000);
   endtask
   task automatic t_abs;
      setpc(24'h00_4000);
      pc_cyc(24'h00_4000, 32'h0000_0005);
      chk({8'h00, pc_out}, 32'h0000_4000);
      xfer(1'b0, 8'h40, 32'h0000_0000);
      chk(se, 1'b1);
   endtask
   task automatic t_acc;
      logic [31:0] v;
      for (int s = 0; s < 4; s++)
      begin
         xfer(1'b1, `ADDR_ACC_IDX, s);
         xfer(1'b1, `ADDR_ACC_LO, 32'h5a10_2030 + s * 32'h0001_0101);
         xfer(1'b1, `ADDR_ACC_HI, 32'h0000_00a5);
      end
      for (int s = 0; s < 4; s++)
      begin
         v = 32'h5a10_2030 + s * 32'h0001_0101;
         run(32'h9100_fc00 | (s << 16), 32'h0000_0000);
         pc_cyc(v[23:0], 32'h0000_000a);
      end
   endtask
   // short and long relative forms, alternately with a buffer hit
   task automatic t_rel;
      logic [31:0] ins [4] = '{32'h4a10_0000, 32'h4a70_0000, 32'h06ff_0000, 32'h0600_4000};
      logic [23:0] tg [4] = '{24'h00_2012, 24'h00_1ff2, 24'h00_1f03, 24'h00_2043};
      for (int i = 0; i < 4; i++)
      begin
         setpc(24'h00_2000);
         run(ins[i], i[0] ? 32'h0000_0002 : 32'h0000_0000);
         pc_cyc(tg[i], i[0] ? 32'h0000_0003 : 32'h0000_0006);
      end
   endtask
   task automatic t_band;
      logic [31:0] ins [4] = '{32'hf200_0060, 32'hf300_0003, 32'hf200_0003, 32'hf300_0040};
      logic [1:0] tf [4] = '{2'b11, 2'b01, 2'b00, 2'b10};
      xfer(1'b1, `ADDR_FLAGS, 32'h0000_0002);
      xfer(1'b1, `ADDR_MEMOP, 32'h0000_0040);
      for (int i = 0; i < 4; i++)
      begin
         run(ins[i], 32'h0000_0000);
         xfer(1'b0, `ADDR_FLAGS, 32'h0000_0000);
         chk(rv[1:0], tf[i]);
         xfer(1'b0, `ADDR_CYCLES, 32'h0000_0000);
         chk(rv, 32'h0000_0001);
      end
      xfer(1'b0, `ADDR_MEMOP, 32'h0000_0000);
      chk(rv, 32'h0000_0040);
      // test flags left by the last two AND tests feed the condition path
      setpc(24'h00_3000);
      run(32'h0461_1000, 32'h0000_0000);
      pc_cyc(24'h00_3013, 32'h0000_0006);
      setpc(24'h00_3000);
      run(32'h0460_1000, 32'h0000_0000);
      pc_cyc(24'h00_3003, 32'h0000_0005);
   endtask
   // carry, overflow, test flag and accumulator conditions, both forms
   task automatic t_bcc;
      logic [31:0] fl [8] = '{32'h004, 32'h000, 32'h020, 32'h001, 32'h001, 32'h000, 32'h100, 32'h200};
      logic [6:0] cd [8] = '{7'h40, 7'h40, 7'h21, 7'h60, 7'h62, 7'h00, 7'h00, 7'h00};
      logic [7:0] tk = 8'b0010_1101;
      logic [7:0] lg = 8'b1000_0100;
      xfer(1'b1, `ADDR_ACC_IDX, 32'h0000_0000);
      xfer(1'b1, `ADDR_ACC_LO, 32'h0000_0000);
      xfer(1'b1, `ADDR_ACC_HI, 32'h0000_0001);
      for (int i = 0; i < 8; i++)
      begin
         setpc(24'h00_3000);
         xfer(1'b1, `ADDR_FLAGS, fl[i]);
         run(lg[i] ? {8'h6d, 1'b0, cd[i], 16'hff00} : {8'h04, 1'b0, cd[i], 16'h1000}, 32'h0000_0000);
         pc_cyc(tk[i] ? (lg[i] ? 24'h00_2f04 : 24'h00_3013) : (lg[i] ? 24'h00_3004 : 24'h00_3003),
            tk[i] ? 32'h0000_0006 : 32'h0000_0005);
         xfer(1'b0, `ADDR_FLAGS, 32'h0000_0000);
         chk(rv[7:4], 4'h0);
      end
      xfer(1'b1, `ADDR_FLAGS, 32'h0000_0000);
   endtask
   task automatic xset(input logic [31:0] i, input logic [31:0] v);
      xfer(1'b1, `ADDR_XAR_IDX, i);
      xfer(1'b1, `ADDR_XAR, v);
   endtask
   task automatic xget(input logic [31:0] i, input logic [31:0] v);
      xfer(1'b1, `ADDR_XAR_IDX, i);
      xfer(1'b0, `ADDR_XAR, 32'h0000_0000);
      chk(rv, v);
   endtask
   task automatic t_xsub;
      xset(0, 32'h0012_3456);
      xset(1, 32'h0043_5634);
      xset(7, 32'h0000_1000);
      xset(8, 32'h0000_8000);
      run(32'h1401_1200, 32'h0000_0000);
      xget(1, 32'h0031_21de);
      xget(0, 32'h0012_3456);
      run(32'h1471_8200, 32'h0000_0000);
      xget(8, 32'h0000_7000);
      xfer(1'b1, `ADDR_FLAGS, 32'h0004_0000);
      xfer(1'b1, `ADDR_CIRC, 32'h0010_0100);
      xset(2, 32'h0000_0105);
      xset(3, 32'h0000_0008);
      run(32'h1431_2200, 32'h0000_0000);
      xget(2, 32'h0000_010d);
      xfer(1'b1, `ADDR_FLAGS, 32'h0000_0000);
   endtask
   // branches under the repeat mode are turned away
   task automatic t_rep;
      setpc(24'h00_4000);
      run(32'h6a00_5000, 32'h0000_0004);
      pc_cyc(24'h00_4000, 32'h0000_0001);
      run(32'h4a10_0000, 32'h0000_0004);
      xfer(1'b0, `ADDR_CTRL, 32'h0000_0000);
      chk(rv[9], 1'b1);
      xfer(1'b1, `ADDR_CTRL, 32'h0000_0000);
   endtask
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_abs;
      t_acc;
      t_rel;
      t_band;
      t_bcc;
      t_xsub;
      t_rep;
      results;
   end
endmodule // branch_and_addr_subtract_exec_bench
`default_nettype wire
